/* File: src/measurement_push_framer.sv */
/*
  Measurement push framer: command port registers, 1 ms windows, frame output.
  Assumes samples and commands synchronous to clk; the byte sink may stall.
*/
`timescale 1ns/1ps
`include "push_consts.svh"
module measurement_push_framer #(
  parameter int TICK_CYC = `TICK_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire push_pkg::cmd_req_s cmd,
  output push_pkg::cmd_rsp_s rsp,
  output logic rsp_valid,
  input wire logic sample_stb,
  input wire logic [3:0] sample_ok,
  input wire logic [127:0] sample_val,
  input wire logic [31:0] sensor_status,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output push_pkg::tx_meta_s tx_meta,
  output logic push_active,
  output logic erase_files
);
  import push_pkg::*;

  localparam int DEPTH = `BUF_WORDS;

  function automatic logic [2:0] ones_below(input logic [3:0] m, input int c);
    logic [2:0] n;
    n = 3'd0;
    for (int i = 0; i < 4; i++)
      if (i < c && m[i])
        n = n + 3'd1;
    return n;
  endfunction

  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] k);
    return w[8'(31 - 8 * int'(k)) -: 8];
  endfunction

  // ==========================================================
  // Configuration registers
  logic [15:0] cmd_entry_q;
  logic [3:0] mask_q;
  logic dir_q;
  logic [15:0] port_q;
  logic [31:0] ip_q;
  logic port_set_q;
  logic ip_set_q;
  logic fault_mode_q;
  logic [31:0] subst_q;
  logic [15:0] supp_q;
  cmd_rsp_s rsp_q;
  logic rsp_valid_q;
  logic erase_q;

  wire is_wr = cmd_valid && cmd.write;
  wire [15:0] a = cmd.addr;
  wire [31:0] wd = cmd.wdata;
  wire hit_entry = a == `OFS_CMD_ENTRY;
  wire hit_mask = a == `OFS_CHAN_MASK;
  wire hit_dir = a == `OFS_MEAS_DIR;
  wire hit_pwide = a == `OFS_PORT_WIDE;
  wire hit_port = a == `OFS_PORT;
  wire hit_ip = a == `OFS_IP;
  wire hit_mode = a == `OFS_FAULT_MODE;
  wire hit_subst = a == `OFS_SUBST_VAL;
  wire hit_supp = a == `OFS_SUPP_MS;
  wire hit_any = hit_entry | hit_mask | hit_dir | hit_pwide | hit_port | hit_ip |
                 hit_mode | hit_subst | hit_supp;
  wire bad_cmd = is_wr && hit_entry && wd != `CMD_ERASE;
  wire ovf = is_wr && ((hit_mask && wd > `MASK_MAX) || (hit_dir && wd > 32'h1) ||
             (hit_pwide && wd > `PORT_MAX) || (hit_port && wd > `PORT_MAX) ||
             (hit_mode && wd > 32'h1) || (hit_supp && wd > `PORT_MAX));
  wire [15:0] err_code;
  wire [31:0] rd_data;
  wire wr_ok = is_wr && hit_any && !bad_cmd && !ovf;

  // Address decoding and error classification
  assign err_code = (a > `OFS_MAX) ? `ERR_ADDR :
                    !hit_any ? `ERR_UNKNOWN :
                    bad_cmd ? `ERR_UNKNOWN :
                    ovf ? `ERR_OVERFLOW : 16'h0000;
  assign rd_data = hit_entry ? {16'h0000, cmd_entry_q} :
                   hit_mask ? {28'h0000000, mask_q} :
                   hit_dir ? {31'h00000000, dir_q} :
                   (hit_pwide || hit_port) ? {16'h0000, port_q} :
                   hit_ip ? ip_q :
                   hit_mode ? {31'h00000000, fault_mode_q} :
                   hit_subst ? subst_q :
                   hit_supp ? {16'h0000, supp_q} : 32'h00000000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_q <= '0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= cmd_valid;
      if (cmd_valid && err_code != 16'h0000)
        rsp_q <= '{error: 1'b1, data: {`ERR_PREFIX, err_code}};
      else if (cmd_valid)
        rsp_q <= '{error: 1'b0, data: cmd.write ? wd : rd_data};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_entry_q <= 16'h0000;
      mask_q <= 4'h0;
      dir_q <= 1'b0;
      port_q <= 16'h0000;
      ip_q <= 32'h00000000;
      port_set_q <= 1'b0;
      ip_set_q <= 1'b0;
      fault_mode_q <= 1'b0;
      subst_q <= 32'h00000000;
      supp_q <= 16'h0000;
      erase_q <= 1'b0;
    end else begin
      erase_q <= wr_ok && hit_entry;
      if (wr_ok && hit_entry)
        cmd_entry_q <= wd[15:0];
      if (wr_ok && hit_mask)
        mask_q <= wd[3:0];
      if (wr_ok && hit_dir)
        dir_q <= wd[0];
      if (wr_ok && (hit_pwide || hit_port)) begin
        port_q <= wd[15:0];
        port_set_q <= 1'b1;
      end
      if (wr_ok && hit_ip) begin
        ip_q <= wd;
        ip_set_q <= 1'b1;
      end
      if (wr_ok && hit_mode)
        fault_mode_q <= wd[0];
      if (wr_ok && hit_subst)
        subst_q <= wd;
      if (wr_ok && hit_supp)
        supp_q <= wd[15:0];
    end
  end

  wire push_ok = port_set_q && ip_set_q && mask_q != 4'h0;

  // ==========================================================
  // Timebase: 1 ms tick, ns stamp, measurement counter
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [31:0] ns_q;
  logic [31:0] meas_cnt_q;
  wire tick_end = tick_cnt_q == 32'(TICK_CYC - 1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
      ns_q <= 32'h00000000;
      meas_cnt_q <= 32'h00000000;
    end else begin
      tick_cnt_q <= tick_end ? 32'h00000000 : tick_cnt_q + 32'h00000001;
      tick_q <= tick_end;
      if (ns_q >= `NS_WRAP - 32'(`CLK_PERIOD_NS))
        ns_q <= 32'h00000000;
      else
        ns_q <= ns_q + 32'(`CLK_PERIOD_NS);
      if (sample_stb)
        meas_cnt_q <= meas_cnt_q + 32'h00000001;
    end
  end

  // ==========================================================
  // Per-channel value conditioning
  logic [31:0] chan_val [4];
  for (genvar g = 0; g < 4; g++) begin : g_chan
    value_guard u_guard (
      .clk(clk),
      .reset_n(reset_n),
      .tick(tick_q),
      .sample_stb(sample_stb),
      .ok(sample_ok[g]),
      .raw(sample_val[32 * g +: 32]),
      .negate(dir_q),
      .subst_mode(fault_mode_q),
      .subst_val(subst_q),
      .supp_ms(supp_q),
      .value(chan_val[g])
    );
  end

  // ==========================================================
  // Window collection into two banks
  logic [31:0] buf_mem [0:2 * DEPTH - 1];
  logic bank_q;
  logic [8:0] wcnt_q;
  logic [3:0] win_mask_q;
  logic [31:0] first_ts_q;
  logic [31:0] first_cnt_q;
  tx_state_e state_q;
  logic [8:0] f_words_q;
  logic f_bank_q;

  wire sending = state_q == ST_SEND;
  wire start_frame = tick_q && push_ok && wcnt_q != 9'd0 && !sending;
  // A window that ends while the previous frame still drains is dropped
  wire wr_bank = start_frame ? !bank_q : bank_q;
  wire [8:0] wr_base = tick_q ? 9'd0 : wcnt_q;
  wire [3:0] wr_mask = tick_q ? mask_q : win_mask_q;
  wire [8:0] wr_n = {6'd0, ones_below(wr_mask, 4)};
  wire wr_fits = 10'(wr_base) + 10'(wr_n) <= 10'(DEPTH);
  wire take = sample_stb && push_ok && wr_mask != 4'h0 && wr_fits;

  always_ff @(posedge clk) begin
    for (int c = 0; c < 4; c++)
      if (take && wr_mask[c])
        buf_mem[{wr_bank, 8'(wr_base + 9'(ones_below(wr_mask, c)))}] <= chan_val[c];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_q <= 1'b0;
      wcnt_q <= 9'd0;
      win_mask_q <= 4'h0;
      first_ts_q <= 32'h00000000;
      first_cnt_q <= 32'h00000000;
    end else begin
      bank_q <= wr_bank;
      if (tick_q)
        win_mask_q <= mask_q;
      if (take)
        wcnt_q <= wr_base + wr_n;
      else if (tick_q)
        wcnt_q <= 9'd0;
      if (take && wr_base == 9'd0) begin
        first_ts_q <= ns_q;
        first_cnt_q <= meas_cnt_q;
      end
    end
  end

  // ==========================================================
  // Frame serialiser
  logic [11:0] len_q;
  logic [111:0] hdr_q;
  logic [10:0] nidx_q;
  logic [10:0] cur_idx_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic tx_last_q;
  tx_meta_s meta_q;
  logic active_q;

  wire [10:0] last_idx = 11'(`HDR_BYTES - 1) + {f_words_q, 2'b00};
  wire [10:0] body_idx = nidx_q - 11'(`HDR_BYTES);
  wire [31:0] body_word = buf_mem[{f_bank_q, body_idx[9:2]}];
  wire [7:0] next_byte = (nidx_q < 11'(`HDR_BYTES)) ?
                         hdr_q[8'(111 - 8 * int'(nidx_q)) -: 8] :
                         word_byte(body_word, body_idx[1:0]);
  wire load = sending && (!tx_valid_q || tx_ready);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      f_words_q <= 9'd0;
      f_bank_q <= 1'b0;
      len_q <= 12'h000;
      hdr_q <= '0;
      nidx_q <= 11'd0;
      cur_idx_q <= 11'd0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
      meta_q <= '0;
      active_q <= 1'b0;
    end else begin
      active_q <= push_ok;
      case (state_q)
        ST_IDLE: begin
          if (start_frame) begin
            state_q <= ST_SEND;
            f_words_q <= wcnt_q;
            f_bank_q <= bank_q;
            len_q <= 12'(`HDR_BODY) + {1'b0, wcnt_q, 2'b00};
            hdr_q <= {`PUSH_TAG, 12'(`HDR_BODY) + {1'b0, wcnt_q, 2'b00},
                      sensor_status, first_ts_q, first_cnt_q};
            meta_q <= '{dst_ip: ip_q, dst_port: port_q, data_port: `DATA_PORT};
            nidx_q <= 11'd0;
          end
        end
        ST_SEND: begin
          if (load && nidx_q <= last_idx) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= next_byte;
            tx_last_q <= nidx_q == last_idx;
            cur_idx_q <= nidx_q;
            nidx_q <= nidx_q + 11'd1;
          end else if (load) begin
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign rsp = rsp_q;
  assign rsp_valid = rsp_valid_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_last = tx_last_q;
  assign tx_meta = meta_q;
  assign push_active = active_q;
  assign erase_files = erase_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_TICK_PERIOD: assert property (tick_q |-> $past(tick_cnt_q) == 32'(TICK_CYC - 1))
    else $error("tick not on period end");
  AST_FRAME_START: assert property (start_frame |=> sending && hdr_q[111:108] == 4'hD)
    else $error("frame did not start on tick");
  AST_NO_PUSH: assert property (!sending && !push_ok |=> !sending)
    else $error("frame started without full config");
  AST_MASK_STOP: assert property (mask_q == 4'h0 |-> ##1 !active_q)
    else $error("push active with empty mask");
  AST_HDR_TAG: assert property (tx_valid_q && cur_idx_q == 11'd0 |-> tx_data_q[7:4] == 4'hD)
    else $error("first byte lacks tag");
  AST_LEN: assert property (sending |-> len_q == 12'd12 + {1'b0, f_words_q, 2'b00})
    else $error("length field wrong");
  AST_NS_WRAP: assert property (ns_q < `NS_WRAP)
    else $error("time stamp beyond one second");
  AST_ERR_PREFIX: assert property (rsp_valid_q && rsp_q.error |-> rsp_q.data[31:16] == 16'hE002)
    else $error("error reply lacks prefix");
  AST_OVF: assert property (is_wr && hit_mask && wd > 32'hF |=> rsp_q.data == 32'hE00200E9)
    else $error("mask overflow not reported");
  // Back-to-back erase commands keep the pulse high, so each cycle is checked on its own
  wire erase_cmd = is_wr && hit_entry && wd == `CMD_ERASE;

  AST_ERASE: assert property (is_wr && hit_entry && wd == 32'h24E |=> erase_q)
    else $error("erase pulse missing");
  AST_ERASE_ONLY: assert property (erase_q |-> $past(erase_cmd))
    else $error("erase pulse without erase command");

  CV_FRAME_DONE: cover property (tx_valid_q && tx_ready && tx_last_q);
  CV_ERR_REPLY: cover property (rsp_valid_q && rsp_q.error);
  CV_MULTI_CHAN: cover property (start_frame && win_mask_q == 4'h3);
endmodule // measurement_push_framer

/* File: src/push_consts.svh */
/*
  Constants of the measurement push framer: offsets, field codes, timing.
  Assumes a 40 MHz clock; included by bare name.
*/
`ifndef PUSH_CONSTS_SVH
`define PUSH_CONSTS_SVH
// ==========================================================
// Register offsets
`define OFS_CMD_ENTRY 16'h004C
`define OFS_CHAN_MASK 16'h01E0
`define OFS_MEAS_DIR 16'h0CA4
`define OFS_PORT_WIDE 16'h10E0
`define OFS_PORT 16'h10E2
`define OFS_IP 16'h10E4
`define OFS_FAULT_MODE 16'h1100
`define OFS_SUBST_VAL 16'h1104
`define OFS_SUPP_MS 16'h1108
`define OFS_MAX 16'h1FFF
// ==========================================================
// Codes and values
`define CMD_ERASE 32'h0000024E
`define MASK_MAX 32'h0000000F
`define PORT_MAX 32'h0000FFFF
`define ERR_PREFIX 16'hE002
`define ERR_UNKNOWN 16'h00E1
`define ERR_ADDR 16'h00E2
`define ERR_OVERFLOW 16'h00E9
`define PUSH_TAG 4'hD
`define HDR_BODY 12
`define HDR_BYTES 14
`define DATA_PORT 16'h1392
`define CTRL_PORT 16'h1393
`define ERR_VALUE 32'h7FFFFFFF
`define BUF_WORDS 256
// ==========================================================
// Timing
`define CLK_PERIOD_NS 25
`define TICK_NS 1000000
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
`define NS_WRAP 32'd1000000000
`endif

/* File: src/push_pkg.sv */
/*
  Types of the measurement push framer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package push_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } tx_state_e;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } cmd_req_s;

  typedef struct packed {
    logic error;
    logic [31:0] data;
  } cmd_rsp_s;

  typedef struct packed {
    logic [31:0] dst_ip;
    logic [15:0] dst_port;
    logic [15:0] data_port;
  } tx_meta_s;
endpackage

/* File: src/value_guard.sv */
/*
  One channel's value conditioning: direction, hold or substitute on failure until supp_ms ms pass, then ERR_VALUE.
  Assumes the tick is a one-cycle pulse each millisecond.
*/
`timescale 1ns/1ps
`include "push_consts.svh"
module value_guard (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic sample_stb,
  input wire logic ok,
  input wire logic [31:0] raw,
  input wire logic negate,
  input wire logic subst_mode,
  input wire logic [31:0] subst_val,
  input wire logic [15:0] supp_ms,
  output logic [31:0] value
);
  logic [31:0] last_q;
  logic [15:0] fail_ms_q;
  logic failing_q;
  logic [31:0] signed_raw;
  logic in_supp;

  assign signed_raw = negate ? 32'(-raw) : raw;
  assign in_supp = fail_ms_q < supp_ms;
  // ==========================================================
  // Output selection
  assign value = ok ? signed_raw :
                 !in_supp ? `ERR_VALUE :
                 subst_mode ? subst_val :
                 last_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= 32'h00000000;
      fail_ms_q <= 16'h0000;
      failing_q <= 1'b0;
    end else if (sample_stb && ok) begin
      last_q <= signed_raw;
      fail_ms_q <= 16'h0000;
      failing_q <= 1'b0;
    end else begin
      if (sample_stb)
        failing_q <= 1'b1;
      if (tick && failing_q && in_supp)
        fail_ms_q <= fail_ms_q + 16'h0001;
    end
  end
endmodule // value_guard

/* File: verification/measurement_push_framer_bench.sv */
/*
  Self-checking bench of the push framer: commands, windows of samples, frames.
  Assumes the framer, the byte sink model and a 40 MHz clock.
*/
`timescale 1ns/1ps
`include "push_consts.svh"
module measurement_push_framer_bench;
  import push_pkg::*;
  localparam int TCYC = 200;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_req_s cmd = '0;
  cmd_rsp_s rsp;
  logic rsp_valid, tx_valid, tx_last, tx_ready, push_active, erase_files;
  logic [7:0] tx_data;
  tx_meta_s tx_meta;
  logic sample_stb = 1'b0;
  logic [3:0] sample_ok = 4'h0;
  logic [127:0] sample_val = '0;
  logic [31:0] sensor_status = 32'h0;
  logic stall = 1'b0;
  integer seed = 32'h079E34BD;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_strb = 0;
  int n_erase = 0;
  int bi = 0;
  logic [32:0] rsp_q[$];
  logic [8:0] exp_q[$];
  logic [63:0] ref_q[$];
  logic [31:0] last_v[4] = '{default: 32'h0};
  logic [31:0] subst_v = 32'h0;
  logic [31:0] ts, cnt, pts, pcnt;
  logic [63:0] r, pr;
  logic [63:0] meta_exp = {32'hC0A8000A, 16'h1388, `DATA_PORT};
  logic [8:0] e;
  bit dir = 0;
  bit subst = 0;
  bit supp0 = 0;
  bit have_prev = 0;

  measurement_push_framer #(.TICK_CYC(TCYC)) i_dut (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp), .rsp_valid(rsp_valid),
    .sample_stb(sample_stb), .sample_ok(sample_ok), .sample_val(sample_val),
    .sensor_status(sensor_status), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .tx_meta(tx_meta),
    .push_active(push_active), .erase_files(erase_files));
  push_sink i_sink (.clk(clk), .reset_n(reset_n), .stall(stall), .tx_ready(tx_ready));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (reset_n) begin
      cyc <= cyc + 1;
    end
  end

  // ==========================================================
  // Comparison and closing
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // ==========================================================
  // Drivers
  task automatic do_cmd(input logic w, input logic [15:0] a, input logic [31:0] d,
                        input logic [32:0] rs);
    cmd_valid <= 1'b1;
    cmd <= '{write: w, addr: a, wdata: d};
    rsp_q.push_back(rs);
    @(posedge clk);
  endtask

  task automatic idle();
    cmd_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] cond(int c, logic ok, logic [31:0] raw);
    if (ok) begin
      last_v[c] = dir ? (~raw + 32'h1) : raw;
      return last_v[c];
    end
    return supp0 ? `ERR_VALUE : (subst ? subst_v : last_v[c]);
  endfunction

  task automatic window(input int n, input logic [3:0] m, input logic [3:0] okm, input bit live);
    logic [7:0] fb[$];
    logic [31:0] w[$];
    logic [31:0] raw;
    logic [15:0] len;
    int g;
    g = 0;
    while (cyc % TCYC != 40) begin
      @(posedge clk);
      g++;
      if (g > 2 * TCYC) begin
        n_fail++;
        results();
      end
    end
    w.push_back($random(seed));
    sensor_status <= w[0];
    w.push_back(32'h0);
    w.push_back(32'h0);
    for (int i = 0; i < n; i++) begin
      if (i == 0 && live) begin
        ref_q.push_back({32'($time), 32'(n_strb)});
      end
      sample_stb <= 1'b1;
      sample_ok <= okm;
      for (int c = 0; c < 4; c++) begin
        raw = $random(seed);
        sample_val[32 * c +: 32] <= raw;
        raw = cond(c, okm[c], raw);
        if (m[c] && live) begin
          w.push_back(raw);
        end
      end
      n_strb++;
      @(posedge clk);
      sample_stb <= 1'b0;
      @(posedge clk);
    end
    if (w.size() > 3) begin
      len = 16'(4 * w.size());
      fb.push_back({`PUSH_TAG, len[11:8]});
      fb.push_back(len[7:0]);
      foreach (w[k]) begin
        for (int b = 3; b >= 0; b--) begin
          fb.push_back(w[k][8 * b +: 8]);
        end
      end
      foreach (fb[j]) begin
        exp_q.push_back({j == fb.size() - 1, fb[j]});
      end
    end
  endtask

  // ==========================================================
  // Watchers of answers and frame bytes
  always @(posedge clk) begin
    if (erase_files) begin
      n_erase++;
    end
    if (rsp_valid) begin
      check({31'h0, rsp}, {31'h0, rsp_q.pop_front()}, "answer");
    end
    if (tx_valid && tx_ready) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
      if (bi == 0) begin
        check(tx_meta, meta_exp, "frame target");
      end
      if (bi < 6 || bi > 13) begin
        check({tx_last, tx_data}, e, "frame byte");
      end else if (bi < 10) begin
        ts = {ts[23:0], tx_data};
      end else begin
        cnt = {cnt[23:0], tx_data};
      end
      if (bi == 13) begin
        r = ref_q.pop_front();
        if (have_prev) begin
          check(ts - pts, r[63:32] - pr[63:32], "time stamp gap");
          check(cnt - pcnt, r[31:0] - pr[31:0], "counter gap");
        end
        have_prev = 1;
        pr = r;
        pts = ts;
        pcnt = cnt;
      end
      bi = tx_last ? 0 : bi + 1;
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    int g;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    do_cmd(1'b1, `OFS_CHAN_MASK, 32'h10, {1'b1, `ERR_PREFIX, `ERR_OVERFLOW});
    do_cmd(1'b1, 16'h2000, 32'h0, {1'b1, `ERR_PREFIX, `ERR_ADDR});
    do_cmd(1'b0, 16'h0004, 32'h0, {1'b1, `ERR_PREFIX, `ERR_UNKNOWN});
    do_cmd(1'b1, `OFS_CMD_ENTRY, 32'h1, {1'b1, `ERR_PREFIX, `ERR_UNKNOWN});
    do_cmd(1'b1, `OFS_CMD_ENTRY, `CMD_ERASE, {1'b0, `CMD_ERASE});
    do_cmd(1'b1, `OFS_PORT, 32'h10000, {1'b1, `ERR_PREFIX, `ERR_OVERFLOW});
    do_cmd(1'b1, `OFS_MEAS_DIR, 32'h2, {1'b1, `ERR_PREFIX, `ERR_OVERFLOW});
    do_cmd(1'b1, `OFS_PORT, 32'h1388, {1'b0, 32'h1388});
    do_cmd(1'b1, `OFS_PORT_WIDE, 32'h1388, {1'b0, 32'h1388});
    do_cmd(1'b0, `OFS_PORT_WIDE, 32'h0, {1'b0, 32'h1388});
    do_cmd(1'b1, `OFS_CHAN_MASK, 32'h3, {1'b0, 32'h3});
    idle();
    check(push_active, 1'b0, "active without target");
    window(3, 4'h3, 4'hF, 0);
    done("commands");
    do_cmd(1'b1, `OFS_IP, 32'hC0A8000A, {1'b0, 32'hC0A8000A});
    idle();
    check(push_active, 1'b1, "active");
    stall <= 1'b1;
    window(4, 4'h3, 4'hF, 1);
    window(2, 4'h3, 4'hF, 1);
    done("frames");
    window(0, 4'h0, 4'hF, 0);
    dir = 1;
    do_cmd(1'b1, `OFS_CHAN_MASK, 32'hF, {1'b0, 32'hF});
    do_cmd(1'b1, `OFS_MEAS_DIR, 32'h1, {1'b0, 32'h1});
    idle();
    window(3, 4'hF, 4'hF, 1);
    window(0, 4'h0, 4'hF, 0);
    dir = 0;
    do_cmd(1'b1, `OFS_MEAS_DIR, 32'h0, {1'b0, 32'h0});
    do_cmd(1'b1, `OFS_SUPP_MS, 32'h5, {1'b0, 32'h5});
    idle();
    window(2, 4'hF, 4'hA, 1);
    window(0, 4'h0, 4'hF, 0);
    subst = 1;
    subst_v = $random(seed);
    do_cmd(1'b1, `OFS_FAULT_MODE, 32'h1, {1'b0, 32'h1});
    do_cmd(1'b1, `OFS_SUBST_VAL, subst_v, {1'b0, subst_v});
    idle();
    window(2, 4'hF, 4'h5, 1);
    window(0, 4'h0, 4'hF, 0);
    supp0 = 1;
    do_cmd(1'b1, `OFS_SUPP_MS, 32'h0, {1'b0, 32'h0});
    idle();
    window(2, 4'hF, 4'h3, 1);
    done("fault handling");
    window(0, 4'h0, 4'hF, 0);
    do_cmd(1'b1, `OFS_CHAN_MASK, 32'h0, {1'b0, 32'h0});
    idle();
    check(push_active, 1'b0, "stopped");
    window(2, 4'hF, 4'hF, 0);
    g = 0;
    while ((exp_q.size() > 0 || bi != 0) && g < 1000) begin
      @(posedge clk);
      g++;
    end
    check(64'(exp_q.size()), 64'h0, "frames missing");
    check(64'(n_erase), 64'h1, "erase pulses");
    done("stop");
    results();
  end
endmodule // measurement_push_framer_bench

/* File: verification/push_sink.sv */
/*
  Host-side byte sink for the push framer: takes frame bytes and stalls at random.
  Assumes the framer's clock and active-low reset.
*/
`timescale 1ns/1ps
module push_sink (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic stall,
  output logic tx_ready
);
  integer seed = 32'h079E34BD;
  // ==========================================================
  // Ready pattern, random gaps while stall is set
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= !stall || ($random(seed) % 3 != 0);
    end
  end
endmodule // push_sink
